// ===== cafim_id_match.sv
// Acceptance filter identifier match with an AXI4-Lite register slave.
//
// Operation
// (RL1) Bits 15:5 hold standard identifier; every bit must equal received.
// (RL2) Bits 4 and 2 read zero; writes to them ignored.
// (RL3) Type enable set and selector one: accept only extended identifiers.
// (RL4) Type enable set and selector zero: accept only standard ids.
// (RL5) Type enable clear: selector ignored, type no criterion.
// (RL6) Bits 1:0 hold extended bits 17:16; each must match.
// (RL7) Hit only when all enabled comparisons succeed together.
`timescale 1ns/100ps
`include "cafim_cfg.svh"
module cafim_id_match (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write address.
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Received identifier from the receiver.
    input  wire logic [10:0] rx_std_id,
    input  wire logic [17:0] rx_ext_id,
    input  wire logic        rx_is_ext,
    input  wire logic        rx_id_valid,
    // Match result.
    output logic             filter_hit,
    output logic [3:0]       filter_hit_index,
    output logic             filter_result_valid
);
    localparam int NF = `CAFIM_NUM_FILTERS;

    // Filter storage has no defined reset value.
    logic [15:0] filt_q [NF];
    logic [15:0] filt_d [NF];
    logic [NF-1:0] type_en_q;
    logic [NF-1:0] type_en_d;
    logic [NF-1:0] slot_en_q;
    logic [NF-1:0] slot_en_d;
    logic [NF-1:0] hits;

    cafim_pkg::cafim_wstate_t wst_q;
    cafim_pkg::cafim_wstate_t wst_d;
    cafim_pkg::cafim_rstate_t rst_st_q;
    cafim_pkg::cafim_rstate_t rst_st_d;
    logic        aw_have_q;
    logic        aw_have_d;
    logic        w_have_q;
    logic        w_have_d;
    logic [11:0] awaddr_q;
    logic [11:0] awaddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0]  wstrb_q;
    logic [3:0]  wstrb_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic        hit_q;
    logic        hit_d;
    logic [3:0]  idx_q;
    logic [3:0]  idx_d;
    logic        res_v_q;
    logic        res_v_d;
    // Handshake outputs are registered from the next state, so they open
    // one cycle after reset is released.
    logic        awready_q;
    logic        wready_q;
    logic        arready_q;
    logic        bvalid_q;
    logic        rvalid_q;

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_cmp
            cafim_filter_cmp u_cmp (
                .filt_word            (filt_q[g]),
                .id_type_match_enable (type_en_q[g]),
                .rx_std_id            (rx_std_id),
                .rx_ext_id            (rx_ext_id),
                .rx_is_ext            (rx_is_ext),
                .hit                  (hits[g])
            );
        end
    endgenerate

    // Write channel and register update.
    always_comb begin
        logic [11:0] a;
        logic [15:0] wmask;
        a         = awaddr_q;
        wmask     = 16'h0000;
        wst_d     = wst_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bresp_d   = bresp_q;
        type_en_d = type_en_q;
        slot_en_d = slot_en_q;
        for (int i = 0; i < NF; i++) begin
            filt_d[i] = filt_q[i];
        end
        case (wst_q)
            cafim_pkg::CAFIM_W_IDLE: begin
                if (s_axi_awvalid && awready_q) begin
                    aw_have_d = 1'b1;
                    awaddr_d  = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q) begin
                    w_have_d = 1'b1;
                    wdata_d  = s_axi_wdata;
                    wstrb_d  = s_axi_wstrb;
                end
                if (aw_have_q && w_have_q) begin
                    aw_have_d = 1'b0;
                    w_have_d  = 1'b0;
                    wst_d     = cafim_pkg::CAFIM_W_RESP;
                    bresp_d   = `CAFIM_RESP_OKAY;
                    wmask     = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
                    // (RL2) unimplemented bits not written
                    wmask     = wmask & `CAFIM_WRITE_MASK;
                    if (a[11:6] == `CAFIM_FILTER_BASE >> 6) begin
                        filt_d[a[5:2]] = (filt_q[a[5:2]] & ~wmask)
                                       | (wdata_q[15:0] & wmask);
                    end else if (a[11:2]
                                 == `CAFIM_MASK_TYPE_EN_ADDR >> 2) begin
                        if (wstrb_q[0]) type_en_d[7:0] = wdata_q[7:0];
                        if (wstrb_q[1]) type_en_d[15:8] = wdata_q[15:8];
                    end else if (a[11:2] == `CAFIM_CTRL_ADDR >> 2) begin
                        if (wstrb_q[0]) slot_en_d[7:0] = wdata_q[7:0];
                        if (wstrb_q[1]) slot_en_d[15:8] = wdata_q[15:8];
                    end else begin
                        bresp_d = `CAFIM_RESP_SLVERR;
                    end
                end
            end
            cafim_pkg::CAFIM_W_RESP: begin
                if (s_axi_bready) begin
                    wst_d = cafim_pkg::CAFIM_W_IDLE;
                end
            end
            default: wst_d = cafim_pkg::CAFIM_W_IDLE;
        endcase
    end

    // Read channel.
    always_comb begin
        rst_st_d = rst_st_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        case (rst_st_q)
            cafim_pkg::CAFIM_R_IDLE: begin
                if (s_axi_arvalid && arready_q) begin
                    rst_st_d = cafim_pkg::CAFIM_R_DATA;
                    rresp_d  = `CAFIM_RESP_OKAY;
                    rdata_d  = 32'h0000_0000;
                    if (s_axi_araddr[11:6] == `CAFIM_FILTER_BASE >> 6) begin
                        // (RL2) unimplemented bits read zero
                        rdata_d[15:0] = filt_q[s_axi_araddr[5:2]]
                                      & `CAFIM_WRITE_MASK;
                    end else if (s_axi_araddr[11:2]
                                 == `CAFIM_MASK_TYPE_EN_ADDR >> 2) begin
                        rdata_d[15:0] = type_en_q;
                    end else if (s_axi_araddr[11:2]
                                 == `CAFIM_ID_ADDR >> 2) begin
                        rdata_d = {2'b00, rx_is_ext, rx_std_id, rx_ext_id};
                    end else if (s_axi_araddr[11:2]
                                 == `CAFIM_CTRL_ADDR >> 2) begin
                        rdata_d[15:0] = slot_en_q;
                    end else if (s_axi_araddr[11:2]
                                 == `CAFIM_STATUS_ADDR >> 2) begin
                        rdata_d = {26'h000_0000, res_v_q, hit_q, idx_q};
                    end else begin
                        rresp_d = `CAFIM_RESP_SLVERR;
                    end
                end
            end
            cafim_pkg::CAFIM_R_DATA: begin
                if (s_axi_rready) begin
                    rst_st_d = cafim_pkg::CAFIM_R_IDLE;
                end
            end
            default: rst_st_d = cafim_pkg::CAFIM_R_IDLE;
        endcase
    end

    // Match result: lowest enabled slot that hits wins.
    always_comb begin
        hit_d   = 1'b0;
        idx_d   = 4'h0;
        res_v_d = rx_id_valid;
        for (int i = NF - 1; i >= 0; i--) begin
            // (RL7) hit needs slot enabled and full match
            if (slot_en_q[i] && hits[i]) begin
                hit_d = rx_id_valid;
                idx_d = 4'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NF; i++) begin
            filt_q[i] <= filt_d[i];
        end
        awaddr_q <= awaddr_d;
        wdata_q  <= wdata_d;
        wstrb_q  <= wstrb_d;
        rdata_q  <= rdata_d;
        if (rst) begin
            wst_q     <= cafim_pkg::CAFIM_W_IDLE;
            rst_st_q  <= cafim_pkg::CAFIM_R_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bresp_q   <= 2'b00;
            rresp_q   <= 2'b00;
            type_en_q <= 16'h0000;
            slot_en_q <= 16'h0000;
            hit_q     <= 1'b0;
            idx_q     <= 4'h0;
            res_v_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            rvalid_q  <= 1'b0;
        end else begin
            wst_q     <= wst_d;
            rst_st_q  <= rst_st_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            type_en_q <= type_en_d;
            slot_en_q <= slot_en_d;
            hit_q     <= hit_d;
            idx_q     <= idx_d;
            res_v_q   <= res_v_d;
            awready_q <= !aw_have_d && (wst_d == cafim_pkg::CAFIM_W_IDLE);
            wready_q  <= !w_have_d && (wst_d == cafim_pkg::CAFIM_W_IDLE);
            arready_q <= (rst_st_d == cafim_pkg::CAFIM_R_IDLE);
            bvalid_q  <= (wst_d == cafim_pkg::CAFIM_W_RESP);
            rvalid_q  <= (rst_st_d == cafim_pkg::CAFIM_R_DATA);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign filter_hit          = hit_q;
    assign filter_hit_index    = idx_q;
    assign filter_result_valid = res_v_q;
endmodule : cafim_id_match

// ===== cafim_cfg.svh
// Constants for the acceptance filter identifier match block.
`ifndef CAFIM_CFG_SVH
`define CAFIM_CFG_SVH
`define CAFIM_NUM_FILTERS       16
`define CAFIM_FILTER_BASE       12'h000
`define CAFIM_MASK_TYPE_EN_ADDR 12'h040
`define CAFIM_ID_ADDR           12'h044
`define CAFIM_CTRL_ADDR         12'h048
`define CAFIM_STATUS_ADDR       12'h04c
`define CAFIM_STD_MSB           15
`define CAFIM_STD_LSB           5
`define CAFIM_TYPE_BIT          3
`define CAFIM_EXT_MSB           1
`define CAFIM_EXT_LSB           0
`define CAFIM_WRITE_MASK        16'hffeb
`define CAFIM_RESP_OKAY         2'b00
`define CAFIM_RESP_SLVERR       2'b10
`endif

// ===== cafim_pkg.sv
// Types for the acceptance filter identifier match block.
package cafim_pkg;
    typedef enum logic [1:0] {
        CAFIM_W_IDLE = 2'b00,
        CAFIM_W_RESP = 2'b01
    } cafim_wstate_t;
    typedef enum logic [1:0] {
        CAFIM_R_IDLE = 2'b00,
        CAFIM_R_DATA = 2'b01
    } cafim_rstate_t;
endpackage : cafim_pkg

// ===== cafim_filter_cmp.sv
// One filter slot compared against a received identifier.
`timescale 1ns/100ps
`include "cafim_cfg.svh"
module cafim_filter_cmp (
    // Stored filter word.
    input  wire logic [15:0] filt_word,
    input  wire logic        id_type_match_enable,
    // Received identifier.
    input  wire logic [10:0] rx_std_id,
    input  wire logic [17:0] rx_ext_id,
    input  wire logic        rx_is_ext,
    // Result.
    output logic             hit
);
    logic std_ok;
    logic ext_ok;
    logic type_ok;
    always_comb begin
        // (RL1) standard bits compare
        std_ok = (filt_word[`CAFIM_STD_MSB:`CAFIM_STD_LSB] == rx_std_id);
        // (RL6) extended upper bits compare
        ext_ok = (filt_word[`CAFIM_EXT_MSB:`CAFIM_EXT_LSB]
                  == rx_ext_id[17:16]);
        // (RL3) (RL4) (RL5) type check gated
        if (id_type_match_enable) begin
            type_ok = (filt_word[`CAFIM_TYPE_BIT] == rx_is_ext);
        end else begin
            type_ok = 1'b1;
        end
        // (RL7) all comparisons at once
        hit = std_ok && ext_ok && type_ok;
    end
endmodule : cafim_filter_cmp

// ===== cafim_id_match_properties.sv
// Timing checks on the bus and match ports of the filter block.
`timescale 1ns/100ps
`include "cafim_cfg.svh"
module cafim_id_match_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst,
    // Register bus handshakes.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // Match path.
    input wire logic        rx_id_valid,
    input wire logic        filter_hit,
    input wire logic [3:0]  filter_hit_index,
    input wire logic        filter_result_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_wr_answer:
        assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    chk_rd_answer:
        assert property (rd_take |=> s_axi_rvalid)
        else $error("read data not on time");
    chk_aw_block:
        assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    chk_err_zero:
        assert property (s_axi_rvalid && s_axi_rresp == `CAFIM_RESP_SLVERR
            |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    chk_res_valid:
        assert property (rx_id_valid |=> filter_result_valid)
        else $error("result valid missing");
    chk_res_idle:
        assert property (!rx_id_valid |=> !filter_result_valid && !filter_hit)
        else $error("result without identifier");
    chk_hit_cause:
        assert property (filter_hit |-> filter_result_valid)
        else $error("hit without result valid");
    chk_idx_none:
        assert property (filter_result_valid && !filter_hit
            |-> filter_hit_index == 4'h0)
        else $error("index set without hit");
endmodule : cafim_id_match_chk
bind cafim_id_match cafim_id_match_chk chk_u (.*);

// ===== cafim_can_node.sv
// Model of the bus node side that hands received identifiers to the filter.
`timescale 1ns/100ps
module cafim_can_node (
    // Clock.
    input  wire logic        clk,
    // Received identifier.
    output logic [10:0]      rx_std_id,
    output logic [17:0]      rx_ext_id,
    output logic             rx_is_ext,
    output logic             rx_id_valid
);
    initial begin
        rx_std_id = 11'h0;
        rx_ext_id = 18'h0;
        rx_is_ext = 1'h0;
        rx_id_valid = 1'h0;
    end
    // One identifier for one cycle; the lines are scrambled afterwards.
    task automatic send(input logic [10:0] s, input logic [1:0] e,
                        input logic x);
        @(posedge clk);
        rx_std_id <= s;
        rx_ext_id <= {e, 16'h5a5a};
        rx_is_ext <= x;
        rx_id_valid <= 1'h1;
        @(posedge clk);
        rx_std_id <= ~s;
        rx_ext_id <= ~{e, 16'h5a5a};
        rx_is_ext <= ~x;
        rx_id_valid <= 1'h0;
    endtask : send
endmodule : cafim_can_node

// ===== test_can_accept_filter_id_match.sv
// Register and match tests for the acceptance filter block.
`timescale 1ns/100ps
`include "cafim_cfg.svh"
module test_can_accept_filter_id_match;
    logic        clk = 1'h0, rst = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [10:0] rx_std_id;
    logic [17:0] rx_ext_id;
    logic        rx_is_ext, rx_id_valid;
    logic        filter_hit, filter_result_valid;
    logic [3:0]  filter_hit_index;
    int          n_fail = 0, samples_checked = 0;
    cafim_id_match dut_u (.*);
    cafim_can_node node_u (.*);
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask : rd
    // Slot 3 is the only enabled slot, so a hit must report index 3.
    task automatic hit(input logic [10:0] s, input logic [1:0] e,
                       input logic x, input logic h);
        node_u.send(s, e, x);
        #1;
        chk(filter_result_valid, 32'h1);
        chk(filter_hit, h);
        if (h) chk(filter_hit_index, 32'h3);
    endtask : hit
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(`CAFIM_MASK_TYPE_EN_ADDR, 32'h0, `CAFIM_RESP_OKAY);
        rd(`CAFIM_CTRL_ADDR, 32'h0, `CAFIM_RESP_OKAY);
        wr(12'h00c, 32'hffffffff, `CAFIM_RESP_OKAY);
        rd(12'h00c, 32'h0000ffeb, `CAFIM_RESP_OKAY);
        wr(12'h080, 32'h1, `CAFIM_RESP_SLVERR);
        rd(12'h080, 32'h0, `CAFIM_RESP_SLVERR);
        $display("register tests done");
        wr(12'h00c, 32'h0000b46a, `CAFIM_RESP_OKAY);
        wr(`CAFIM_CTRL_ADDR, 32'h8, `CAFIM_RESP_OKAY);
        wr(`CAFIM_MASK_TYPE_EN_ADDR, 32'h8, `CAFIM_RESP_OKAY);
        hit(11'h5a3, 2'h2, 1'h1, 1'h1);
        hit(11'h5a3, 2'h2, 1'h0, 1'h0);
        hit(11'h5a2, 2'h2, 1'h1, 1'h0);
        hit(11'h1a3, 2'h2, 1'h1, 1'h0);
        hit(11'h5a3, 2'h3, 1'h1, 1'h0);
        hit(11'h5a3, 2'h0, 1'h1, 1'h0);
        wr(`CAFIM_MASK_TYPE_EN_ADDR, 32'h0, `CAFIM_RESP_OKAY);
        hit(11'h5a3, 2'h2, 1'h0, 1'h1);
        hit(11'h5a3, 2'h2, 1'h1, 1'h1);
        wr(`CAFIM_MASK_TYPE_EN_ADDR, 32'h8, `CAFIM_RESP_OKAY);
        wr(12'h00c, 32'h0000b462, `CAFIM_RESP_OKAY);
        hit(11'h5a3, 2'h2, 1'h0, 1'h1);
        hit(11'h5a3, 2'h2, 1'h1, 1'h0);
        wr(`CAFIM_CTRL_ADDR, 32'h0, `CAFIM_RESP_OKAY);
        hit(11'h5a3, 2'h2, 1'h0, 1'h0);
        rd(`CAFIM_ID_ADDR, {2'b00, 1'b1, ~11'h5a3, ~{2'h2, 16'h5a5a}},
           `CAFIM_RESP_OKAY);
        rd(`CAFIM_STATUS_ADDR, 32'h0, `CAFIM_RESP_OKAY);
        wr(`CAFIM_ID_ADDR, 32'h0, `CAFIM_RESP_SLVERR);
        $display("match tests done");
        give_verdict();
    end
endmodule : test_can_accept_filter_id_match
